// ==== arf_dev.sv ====
// Device end: command receiver and regular pattern frame memory filler.
`default_nettype none

module arf_dev
   import arf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   arf_link_if.dev link,
   output logic ram_we,
   output logic ram_red,
   output logic [4:0] ram_x,
   output logic [8:0] ram_y,
   output logic [7:0] ram_wdata,
   output logic [7:0] red_param,
   output logic [7:0] bw_param
);

   // ---------------------------------------------------------------
   // Byte receiver
   // ---------------------------------------------------------------
   logic sclk_ff;
   logic [7:0] shift_ff;
   logic [2:0] bitcnt_ff;
   logic [7:0] nxt_shift;
   logic sclk_rise;
   logic byte_stb;
   arf_dev_state_t state_ff;

   assign sclk_rise = link.sclk & ~sclk_ff;
   assign nxt_shift = {shift_ff[6:0], link.sdin};
   // Write-only link; a read frame is clocked in but never decoded.
   assign byte_stb = sclk_rise & ~link.cs_b & ~link.rw & (bitcnt_ff == 3'h7); // [RULE10]

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sclk_ff <= 1'b0;
      end else begin
         sclk_ff <= link.sclk;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         shift_ff <= 8'h00;
         bitcnt_ff <= 3'h0;
      end else if (link.cs_b) begin
         bitcnt_ff <= 3'h0;
      end else if (sclk_rise) begin
         shift_ff <= nxt_shift;
         bitcnt_ff <= bitcnt_ff + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic pend_ff;
   logic pend_red_ff;
   logic start;

   // Bytes arriving during a fill are dropped; the host is expected to wait.
   assign start = byte_stb & link.dc & pend_ff & (state_ff == DEV_IDLE);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pend_ff <= 1'b0;
         pend_red_ff <= 1'b0;
      end else if (byte_stb && state_ff == DEV_IDLE) begin
         if (!link.dc) begin
            pend_ff <= (nxt_shift == OPC_FILL_RED) || (nxt_shift == OPC_FILL_BW); // [RULE1] [RULE2]
            pend_red_ff <= (nxt_shift == OPC_FILL_RED); // [RULE1]
         end else begin
            pend_ff <= 1'b0; // [RULE1]
         end
      end
   end

   // ---------------------------------------------------------------
   // Pattern parameters
   // ---------------------------------------------------------------
   logic [7:0] red_param_ff;
   logic [7:0] bw_param_ff;
   logic [7:0] act_param;

   assign act_param = nxt_shift;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         red_param_ff <= PARAM_POR; // [RULE8]
         bw_param_ff <= PARAM_POR; // [RULE8]
      end else if (start) begin
         if (pend_red_ff) begin
            red_param_ff <= act_param; // [RULE1]
         end else begin
            bw_param_ff <= act_param; // [RULE2]
         end
      end
   end

   assign red_param = red_param_ff;
   assign bw_param = bw_param_ff;

   // ---------------------------------------------------------------
   // Fill sequencer
   // ---------------------------------------------------------------
   logic fill_red_ff;
   logic first_ff;
   logic [8:0] h_last_ff;
   logic [4:0] w_last_ff;
   logic [4:0] x_ff;
   logic [8:0] y_ff;
   logic [4:0] xs_ff;
   logic [8:0] ys_ff;
   logic xpar_ff;
   logic ypar_ff;
   logic row_end;
   logic fill_end;

   assign row_end = (x_ff == X_LAST);
   assign fill_end = row_end & (y_ff == Y_LAST);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_ff <= DEV_IDLE;
      end else begin
         unique case (state_ff)
            DEV_IDLE: begin
               if (start) begin
                  state_ff <= DEV_FILL;
               end
            end
            DEV_FILL: begin
               if (fill_end) begin
                  state_ff <= DEV_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fill_red_ff <= 1'b0;
         first_ff <= 1'b0;
         h_last_ff <= 9'h000;
         w_last_ff <= 5'h00;
      end else if (start) begin
         fill_red_ff <= pend_red_ff;
         first_ff <= act_param[FIRST_BIT]; // [RULE3]
         h_last_ff <= STEP_H_LINES[act_param[HT_MSB:HT_LSB]] - 9'h001; // [RULE4]
         w_last_ff <= STEP_W_BYTES[act_param[WD_MSB:WD_LSB]] - 5'h01; // [RULE5]
      end
   end

   // X walks one byte per clock; steps toggle the column parity.
   always_ff @(posedge clk_sys) begin
      if (!rst_b || start || row_end) begin
         x_ff <= 5'h00;
         xs_ff <= 5'h00;
         xpar_ff <= 1'b0;
      end else if (state_ff == DEV_FILL) begin
         x_ff <= x_ff + 5'h01;
         if (xs_ff == w_last_ff) begin
            xs_ff <= 5'h00; // [RULE5]
            xpar_ff <= ~xpar_ff;
         end else begin
            xs_ff <= xs_ff + 5'h01;
         end
      end
   end

   // Y advances at the end of each row; each step flips the value.
   always_ff @(posedge clk_sys) begin
      if (!rst_b || start) begin
         y_ff <= 9'h000;
         ys_ff <= 9'h000;
         ypar_ff <= 1'b0;
      end else if (state_ff == DEV_FILL && row_end) begin
         y_ff <= y_ff + 9'h001;
         if (ys_ff == h_last_ff) begin
            ys_ff <= 9'h000; // [RULE4]
            ypar_ff <= ~ypar_ff; // [RULE3]
         end else begin
            ys_ff <= ys_ff + 9'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Frame memory write port and busy
   // ---------------------------------------------------------------
   logic we_ff;
   logic wr_red_ff;
   logic [4:0] wx_ff;
   logic [8:0] wy_ff;
   logic [7:0] wdata_ff;
   logic busy_ff;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         we_ff <= 1'b0;
         wr_red_ff <= 1'b0;
         wx_ff <= 5'h00;
         wy_ff <= 9'h000;
         wdata_ff <= 8'h00;
      end else begin
         we_ff <= (state_ff == DEV_FILL);
         wr_red_ff <= fill_red_ff;
         wx_ff <= x_ff;
         wy_ff <= y_ff;
         wdata_ff <= {8{first_ff ^ ypar_ff ^ xpar_ff}}; // [RULE3]
      end
   end

   // Busy covers the whole fill, including the last registered write.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= start | (state_ff == DEV_FILL); // [RULE9]
      end
   end

   assign ram_we = we_ff;
   assign ram_red = wr_red_ff;
   assign ram_x = wx_ff;
   assign ram_y = wy_ff;
   assign ram_wdata = wdata_ff;
   assign link.busy = busy_ff;

endmodule

`default_nettype wire

// ==== arf_pkg.sv ====
// Constants shared by both ends of the regular pattern autofill link.
//
// Summary of operation
// [RULE1] Opcode 46h fills colour memory, one parameter.
// [RULE2] Opcode 47h fills black/white memory, same parameter.
// [RULE3] Bit 7 sets first step value, alternates in Y.
// [RULE4] Bits 6:4 pick step height 8 to 296.
// [RULE5] Bits 2:0 pick step width 8 to 160.
// [RULE6] Host never sends height code 111.
// [RULE7] Host never sends width codes 110, 111.
// [RULE8] Both pattern parameters reset to 00h.
// [RULE9] Busy stays high while a fill runs.
// [RULE10] Opcode with dc low, parameter dc high, rw low.
// [RULE11] Host waits for busy low before next command.
`default_nettype none

package arf_pkg;

   // ---------------------------------------------------------------
   // Command set
   // ---------------------------------------------------------------
   localparam logic [7:0] OPC_FILL_RED = 8'h46;
   localparam logic [7:0] OPC_FILL_BW = 8'h47;
   localparam logic [7:0] PARAM_POR = 8'h00;

   // ---------------------------------------------------------------
   // Parameter byte layout
   // ---------------------------------------------------------------
   localparam int FIRST_BIT = 7;
   localparam int HT_MSB = 6;
   localparam int HT_LSB = 4;
   localparam int WD_MSB = 2;
   localparam int WD_LSB = 0;
   localparam logic [2:0] HT_BAD = 3'h7;
   localparam logic [2:0] WD_BAD_LO = 3'h6;

   // Undefined codes fall back to a full-panel step on the device side.
   localparam logic [8:0] STEP_H_LINES [0:7] = '{9'h008, 9'h010, 9'h020, 9'h040,
                                                 9'h080, 9'h100, 9'h128, 9'h128};
   localparam logic [4:0] STEP_W_BYTES [0:7] = '{5'h01, 5'h02, 5'h04, 5'h08,
                                                 5'h10, 5'h14, 5'h14, 5'h14};

   // ---------------------------------------------------------------
   // Frame memory geometry, one byte holds eight pixels
   // ---------------------------------------------------------------
   localparam logic [4:0] X_LAST = 5'h13;
   localparam logic [8:0] Y_LAST = 9'h127;

   // ---------------------------------------------------------------
   // Serial link timing and host registers
   // ---------------------------------------------------------------
   localparam logic [2:0] SCLK_HALF_LAST = 3'h3;
   localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
   localparam logic [3:0] OPC_LAST_BIT = 4'h7;
   localparam logic [7:0] ADR_CMD = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam int CMD_RED_BIT = 8;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_ERR_BIT = 2;

   typedef enum logic {DEV_IDLE, DEV_FILL} arf_dev_state_t;
   typedef enum logic [1:0] {HST_IDLE, HST_SEND, HST_WAIT_HI, HST_WAIT_LO} arf_host_state_t;

endpackage

`default_nettype wire

// ==== arf_link_if.sv ====
// Serial command link between the host and the autofill device.
`default_nettype none

interface arf_link_if;
   logic cs_b;
   logic dc;
   logic rw;
   logic sclk;
   logic sdin;
   logic busy;

   modport dev (input cs_b, input dc, input rw, input sclk, input sdin, output busy);
   modport host (output cs_b, output dc, output rw, output sclk, output sdin, input busy);
endinterface

`default_nettype wire

// ==== arf_host.sv ====
// Host end: Wishbone command registers and serial command sender.
`default_nettype none

module arf_host
   import arf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   arf_link_if.host link
);

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   arf_host_state_t state_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic err_ff;
   logic req;
   logic wr_cmd;
   logic wr_stat;
   logic bad_code;
   logic go;

   assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_cmd = req & wb_we_i & wb_sel_i[0] & wb_sel_i[1] & (wb_adr_i == ADR_CMD);
   assign wr_stat = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ADR_STAT);
   assign bad_code = (wb_dat_i[HT_MSB:HT_LSB] == HT_BAD) // [RULE6]
                     | (wb_dat_i[WD_MSB:WD_LSB] >= WD_BAD_LO); // [RULE7]
   // A new command while one is in flight is refused as well.
   assign go = wr_cmd & ~bad_code & (state_ff == HST_IDLE) & ~link.busy; // [RULE11]

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req;
         rdat_ff <= 32'h0000_0000;
         if (req && !wb_we_i && wb_adr_i == ADR_STAT) begin
            rdat_ff[ST_ACTIVE_BIT] <= (state_ff != HST_IDLE);
            rdat_ff[ST_BUSY_BIT] <= link.busy;
            rdat_ff[ST_ERR_BIT] <= err_ff;
         end
      end
   end

   // Sticky refusal flag; a fresh refusal wins over a write-one clear.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         err_ff <= 1'b0;
      end else if (wr_cmd && !go) begin
         err_ff <= 1'b1;
      end else if (wr_stat && wb_dat_i[ST_ERR_BIT]) begin
         err_ff <= 1'b0;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // ---------------------------------------------------------------
   // Serial sender
   // ---------------------------------------------------------------
   logic [15:0] tx_ff;
   logic [3:0] bit_ff;
   logic [2:0] div_ff;
   logic sclk_ff;
   logic sdin_ff;
   logic dc_ff;
   logic cs_b_ff;
   logic tick;
   logic [7:0] opc;

   assign tick = (state_ff == HST_SEND) & (div_ff == SCLK_HALF_LAST);
   assign opc = wb_dat_i[CMD_RED_BIT] ? OPC_FILL_RED : OPC_FILL_BW; // [RULE1] [RULE2]

   always_ff @(posedge clk_sys) begin
      if (!rst_b || state_ff != HST_SEND || tick) begin
         div_ff <= 3'h0;
      end else begin
         div_ff <= div_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_ff <= HST_IDLE;
      end else begin
         unique case (state_ff)
            HST_IDLE: begin
               if (go) begin
                  state_ff <= HST_SEND;
               end
            end
            HST_SEND: begin
               if (tick && sclk_ff && bit_ff == FRAME_LAST_BIT) begin
                  state_ff <= HST_WAIT_HI;
               end
            end
            HST_WAIT_HI: begin
               if (link.busy) begin
                  state_ff <= HST_WAIT_LO;
               end
            end
            HST_WAIT_LO: begin
               if (!link.busy) begin
                  state_ff <= HST_IDLE; // [RULE11]
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tx_ff <= 16'h0000;
         bit_ff <= 4'h0;
         sclk_ff <= 1'b0;
         sdin_ff <= 1'b0;
         dc_ff <= 1'b0;
         cs_b_ff <= 1'b1;
      end else if (go) begin
         tx_ff <= {opc, wb_dat_i[7:0]};
         bit_ff <= 4'h0;
         sdin_ff <= opc[7];
         dc_ff <= 1'b0; // [RULE10]
         cs_b_ff <= 1'b0;
      end else if (tick) begin
         sclk_ff <= ~sclk_ff;
         if (sclk_ff) begin
            if (bit_ff == FRAME_LAST_BIT) begin
               cs_b_ff <= 1'b1;
            end else begin
               tx_ff <= {tx_ff[14:0], 1'b0};
               sdin_ff <= tx_ff[14];
               bit_ff <= bit_ff + 4'h1;
               if (bit_ff == OPC_LAST_BIT) begin
                  dc_ff <= 1'b1; // [RULE10]
               end
            end
         end
      end
   end

   assign link.cs_b = cs_b_ff;
   assign link.dc = dc_ff;
   assign link.rw = 1'b0; // [RULE10]
   assign link.sclk = sclk_ff;
   assign link.sdin = sdin_ff;

endmodule

`default_nettype wire

// ==== arf_link_props.sv ====
// Concurrent checks on the serial link between host and autofill device.
`default_nettype none

module arf_link_props (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic dc,
   input wire logic rw,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic busy
);
   // ---------------------------------------------------------------
   // Helper counters
   // ---------------------------------------------------------------
   // Counters keep long spans out of the properties, which would unroll badly.
   int frm_cnt_ff;
   int busy_cnt_ff;

   always_ff @(posedge clk_sys) begin
      if (!rst_b || cs_b) begin
         frm_cnt_ff <= 0;
      end else begin
         frm_cnt_ff <= frm_cnt_ff + 1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b || !busy) begin
         busy_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= busy_cnt_ff + 1;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   chk_rw_low: assert property (!rw) else $error("rw not low");
   chk_opcode_first: assert property ($fell(cs_b) |-> !dc) else $error("frame starts without dc low");
   chk_dc_rise: assert property ($rose(dc) |-> !cs_b && !sclk) else $error("dc moved outside low sclk");
   chk_sclk_idle: assert property (cs_b |-> !sclk) else $error("sclk not idle outside frame");
   chk_sclk_high: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("sclk high phase not 4");
   chk_sdin_hold: assert property (!cs_b && sclk |-> $stable(sdin)) else $error("sdin moved in high phase");
   chk_frame_len: assert property ($rose(cs_b) |-> frm_cnt_ff inside {[127:129]})
      else $error("frame length wrong");
   chk_busy_start: assert property ($rose(busy) |-> !cs_b && dc) else $error("busy rose outside parameter");
   chk_busy_len: assert property ($fell(busy) |-> busy_cnt_ff inside {[5920:5922]})
      else $error("busy length wrong");
   chk_no_cmd_busy: assert property ($fell(cs_b) |-> !busy) else $error("command sent while busy");
endmodule

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench: host and device joined by the link, driven over Wishbone.
`default_nettype none

module tb_top
   import arf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys;
   logic rst_b;
   logic [7:0] wb_adr_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic wb_we_i;
   logic [3:0] wb_sel_i;
   logic wb_stb_i;
   logic wb_cyc_i;
   logic wb_ack_o;
   logic ram_we;
   logic ram_red;
   logic [4:0] ram_x;
   logic [8:0] ram_y;
   logic [7:0] ram_wdata;
   logic [7:0] red_param;
   logic [7:0] bw_param;
   int miscompares;
   int total_checks;
   int cycles;
   int we_cnt;
   logic [7:0] exp_p;
   logic exp_red;
   logic saw_busy;
   logic [31:0] rd;
   int hts [0:6] = '{8, 16, 32, 64, 128, 256, 296};
   int wbs [0:7] = '{1, 2, 4, 8, 16, 20, 1, 1};
   logic [31:0] bad [0:2] = '{32'h170, 32'h006, 32'h107};

   arf_link_if link();
   arf_dev u_arf_dev (.clk_sys(clk_sys), .rst_b(rst_b), .link(link), .ram_we(ram_we), .ram_red(ram_red),
      .ram_x(ram_x), .ram_y(ram_y), .ram_wdata(ram_wdata), .red_param(red_param), .bw_param(bw_param));
   arf_host u_arf_host (.clk_sys(clk_sys), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
      .wb_ack_o(wb_ack_o), .link(link));
   arf_link_props u_arf_link_props (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(link.cs_b), .dc(link.dc),
      .rw(link.rw), .sclk(link.sclk), .sdin(link.sdin), .busy(link.busy));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   // Automatic, since the memory monitor and the test sequence may both call it at one edge.
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One classic cycle; entered just after a rising edge, waits for ack without assuming a latency.
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      check(n < 50, 1'b1, "wishbone ack");
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_sys);
   endtask

   task start(input logic red, input logic [7:0] p);
      exp_p = p;
      exp_red = red;
      we_cnt = 0;
      saw_busy = 1'b0;
      wb(1'b1, ADR_CMD, {23'h0, red, p});
   endtask

   task finish;
      int n;
      n = 0;
      do begin
         repeat (20) @(posedge clk_sys);
         wb(1'b0, ADR_STAT, 32'h0);
         saw_busy = saw_busy | (rd[ST_BUSY_BIT] === 1'b1);
         n++;
      end while (rd[ST_ACTIVE_BIT] !== 1'b0 && n < 500);
      check(saw_busy, 1'b1, "busy seen");
      check(link.busy, 1'b0, "busy released");
      check(we_cnt, 5920, "write count");
   endtask

   // ---------------------------------------------------------------
   // Clock, timeout and frame memory monitor
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (ram_we === 1'b1) begin
         check({ram_y, ram_x}, {9'(we_cnt / (X_LAST + 1)), 5'(we_cnt % (X_LAST + 1))}, "address order");
         we_cnt++;
         check(ram_red, exp_red, "memory select");
         check(ram_wdata, {8{exp_p[7] ^ ((ram_y / hts[exp_p[6:4]]) % 2 == 1)
            ^ ((ram_x / wbs[exp_p[2:0]]) % 2 == 1)}}, "pixel");
      end
      if (cycles > 90000) begin
         miscompares++;
         $display("BAD %0t timeout", $time);
         conclude();
      end
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      logic [7:0] p;
      logic red;
      rst_b = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_we_i = 1'b0;
      wb_sel_i = 4'hf;
      wb_stb_i = 1'b0;
      wb_cyc_i = 1'b0;
      exp_p = 8'h00;
      exp_red = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      check(red_param, 8'h00, "colour param after reset");
      check(bw_param, 8'h00, "bw param after reset");
      wb(1'b0, ADR_STAT, 32'h0);
      check(rd, 32'h0, "status after reset");
      wb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0, "unmapped read");
      $display("test reset done");
      // Each defined height code is used once and each defined width code at least once, both memories and both first values.
      for (int i = 0; i < 7; i++) begin
         red = ~i[0];
         p = {i[0], i[2:0], 1'b0, 3'(i % 6)};
         start(red, p);
         finish();
         check(red ? red_param : bw_param, p, "param stored");
      end
      $display("test fills done");
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, ADR_CMD, bad[i]);
         wb(1'b0, ADR_STAT, 32'h0);
         check(rd, 32'h4, "undefined code refused");
         wb(1'b1, ADR_STAT, 32'h4);
         wb(1'b0, ADR_STAT, 32'h0);
         check(rd, 32'h0, "error cleared");
      end
      // A command write without both low byte lanes selected must not be taken.
      wb_sel_i <= 4'hc;
      wb(1'b1, ADR_CMD, 32'h111);
      wb_sel_i <= 4'hf;
      wb(1'b0, ADR_STAT, 32'h0);
      check(rd, 32'h0, "partial select ignored");
      $display("test refusals done");
      start(1'b1, 8'h11);
      wb(1'b1, ADR_CMD, 32'h022);
      wb(1'b0, ADR_STAT, 32'h0);
      check(rd[ST_ERR_BIT], 1'b1, "command while active refused");
      check(rd[ST_ACTIVE_BIT], 1'b1, "first fill still active");
      finish();
      check(red_param, 8'h11, "colour param kept");
      check(bw_param, 8'hd5, "bw param untouched");
      $display("test overlap done");
      conclude();
   end
endmodule

`default_nettype wire
